// ### pkg/dio_pkg.sv
package dio_pkg;
  // ===========================================================
  // register offsets within the window
  localparam logic [1:0] OFS_PORT_A = 2'h0;
  localparam logic [1:0] OFS_PORT_B = 2'h1;
  localparam logic [1:0] OFS_PORT_C = 2'h2;
  localparam logic [1:0] OFS_CTRL = 2'h3;
  // ===========================================================
  // control byte fields
  localparam int CTL_SET = 7;
  localparam int CTL_MODE_A_HI = 6;
  localparam int CTL_MODE_A_LO = 5;
  localparam int CTL_DIR_A = 4;
  localparam int CTL_DIR_CHI = 3;
  localparam int CTL_MODE_B = 2;
  localparam int CTL_DIR_B = 1;
  localparam int CTL_DIR_CLO = 0;
  // all inputs, mode 0 after reset
  localparam logic [7:0] CTL_RESET = 8'h9b;
  // ===========================================================
  // interrupt lines on port c and level range
  localparam int IRQ_SRC_BIT = 3;
  localparam int IRQ_DIS_BIT = 7;
  localparam int IRQ_LVL_MIN = 2;
  localparam int IRQ_LVL_NUM = 6;
  localparam logic [2:0] IRQ_LVL_DEF = 3'h2;
  // ===========================================================
  // wait states added when the option is on
  localparam logic [1:0] WAIT_CYCLES = 2'h1;
  typedef enum logic [1:0] {
    DIO_MODE_SIMPLE,
    DIO_MODE_STROBED,
    DIO_MODE_BIDIR
  } dio_mode_e;
endpackage

// ### pkg/dio_sel_if.sv
`timescale 1ns/1ns
// decode result carried from the decoder to the port logic
interface dio_sel_if;
  logic sel;
  logic rd;
  logic wr;
  logic [1:0] reg_idx;
  modport dec (output sel, output rd, output wr, output reg_idx);
  modport use_ (input sel, input rd, input wr, input reg_idx);
endinterface

// ### rtl/dio_decode.sv
`timescale 1ns/1ns
// address window decode, purely combinational
module dio_decode (
  // host bus
  input wire logic [9:0] addr_i,
  input wire logic aen_i,
  input wire logic ior_n_i,
  input wire logic iow_n_i,
  // base switches, one is off
  input wire logic [7:0] base_sw_off_i,
  // decode result
  dio_sel_if.dec sel_o
);
  logic io_cycle;
  // dma cycles raise aen, so the card stays deaf to them
  assign io_cycle = !aen_i && (!ior_n_i || !iow_n_i);
  // off switch compares against a one, on against a zero
  assign sel_o.sel = io_cycle && (addr_i[9:2] == base_sw_off_i);
  assign sel_o.rd = !ior_n_i;
  assign sel_o.wr = !iow_n_i;
  assign sel_o.reg_idx = addr_i[1:0];
endmodule

// ### rtl/dio_card.sv
`timescale 1ns/1ns
// host-side front end of the 24-line digital i/o card
module dio_card (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // host bus
  input wire logic [9:0] addr_i,
  input wire logic aen_i,
  input wire logic ior_n_i,
  input wire logic iow_n_i,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic data_oe_o,
  output logic io_ready_o,
  output logic [5:0] irq_o,
  // straps and jumpers
  input wire logic [7:0] base_sw_off_i,
  input wire logic wait_en_i,
  input wire logic [2:0] irq_level_i,
  // connector ports
  input wire logic [7:0] port_a_byte_i,
  output logic [7:0] port_a_byte_o,
  output logic port_a_byte_oe_o,
  input wire logic [7:0] port_b_byte_i,
  output logic [7:0] port_b_byte_o,
  output logic port_b_byte_oe_o,
  input wire logic [7:0] port_c_byte_i,
  output logic [7:0] port_c_byte_o,
  output logic [7:0] port_c_byte_oe_o,
  // status
  output logic [1:0] mode_a_o,
  output logic mode_b_o
);
  typedef struct packed {
    logic [7:0] ctl;
    logic [7:0] out_a;
    logic [7:0] out_b;
    logic [7:0] out_c;
    logic [7:0] rdata;
    logic [1:0] wait_cnt;
    logic wr_seen;
    logic irq_buf;
    logic [2:0] lvl;
  } dio_st_s;

  dio_st_s st_reg;
  dio_st_s st_next;
  dio_sel_if sel_bus ();
  logic in_a;
  logic in_b;
  logic in_chi;
  logic in_clo;
  logic [7:0] c_view;
  logic [7:0] c_oe;

  dio_decode u_dec (
    .addr_i(addr_i),
    .aen_i(aen_i),
    .ior_n_i(ior_n_i),
    .iow_n_i(iow_n_i),
    .base_sw_off_i(base_sw_off_i),
    .sel_o(sel_bus)
  );

  // ===========================================================
  // direction decode from the control byte
  assign in_a = st_reg.ctl[dio_pkg::CTL_DIR_A];
  assign in_b = st_reg.ctl[dio_pkg::CTL_DIR_B];
  assign in_chi = st_reg.ctl[dio_pkg::CTL_DIR_CHI];
  assign in_clo = st_reg.ctl[dio_pkg::CTL_DIR_CLO];
  assign c_oe = {{4{!in_chi}}, {4{!in_clo}}};
  // driven c lines read back their latch, inputs read the pins live
  assign c_view = (c_oe & st_reg.out_c) | (~c_oe & port_c_byte_i);

  // ===========================================================
  // next state
  always_comb begin
    st_next = st_reg;
    st_next.lvl = irq_level_i;
    st_next.wr_seen = sel_bus.sel && sel_bus.wr;
    // wait counter restarts per cycle, so each access gets one wait
    if (!sel_bus.sel) begin
      st_next.wait_cnt = dio_pkg::WAIT_CYCLES;
    end else if (st_reg.wait_cnt != 2'h0) begin
      st_next.wait_cnt = st_reg.wait_cnt - 2'h1;
    end
    if (sel_bus.sel && sel_bus.rd) begin
      case (sel_bus.reg_idx)
        dio_pkg::OFS_PORT_A: st_next.rdata = in_a ? port_a_byte_i : st_reg.out_a;
        dio_pkg::OFS_PORT_B: st_next.rdata = in_b ? port_b_byte_i : st_reg.out_b;
        dio_pkg::OFS_PORT_C: st_next.rdata = c_view;
        default: st_next.rdata = 8'h00; // control byte is write only
      endcase
    end
    // act once on the leading edge of the write strobe
    if (sel_bus.sel && sel_bus.wr && !st_reg.wr_seen) begin
      case (sel_bus.reg_idx)
        dio_pkg::OFS_PORT_A: st_next.out_a = data_i;
        dio_pkg::OFS_PORT_B: st_next.out_b = data_i;
        dio_pkg::OFS_PORT_C: st_next.out_c = data_i;
        dio_pkg::OFS_CTRL: begin
          if (data_i[dio_pkg::CTL_SET]) begin
            // mode set clears output latches, as the peripheral does
            st_next.ctl = data_i;
            st_next.out_a = 8'h00;
            st_next.out_b = 8'h00;
            st_next.out_c = 8'h00;
          end else begin
            // bit set/reset of one port c line
            st_next.out_c[data_i[3:1]] = data_i[0];
          end
        end
        default: st_next.ctl = st_reg.ctl;
      endcase
    end
    // request buffered, gated by the disable line
    st_next.irq_buf = c_view[dio_pkg::IRQ_SRC_BIT] && !c_view[dio_pkg::IRQ_DIS_BIT];
  end

  // ===========================================================
  // state register
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= '0;
      st_reg.ctl <= dio_pkg::CTL_RESET;
      st_reg.wait_cnt <= dio_pkg::WAIT_CYCLES;
      st_reg.lvl <= dio_pkg::IRQ_LVL_DEF;
    end else begin
      st_reg <= st_next;
    end
  end

  // ===========================================================
  // outputs
  assign data_o = st_reg.rdata;
  assign data_oe_o = sel_bus.sel && sel_bus.rd;
  // ready low only while a wait is owed on a card cycle
  assign io_ready_o = !(wait_en_i && sel_bus.sel && st_reg.wait_cnt != 2'h0);
  assign port_a_byte_o = st_reg.out_a;
  assign port_a_byte_oe_o = !in_a;
  assign port_b_byte_o = st_reg.out_b;
  assign port_b_byte_oe_o = !in_b;
  assign port_c_byte_o = st_reg.out_c;
  assign port_c_byte_oe_o = c_oe;
  assign mode_a_o = st_reg.ctl[dio_pkg::CTL_MODE_A_HI] ? 2'h2 : {1'b0, st_reg.ctl[dio_pkg::CTL_MODE_A_LO]};
  assign mode_b_o = st_reg.ctl[dio_pkg::CTL_MODE_B];

  // one request line per jumper position 2..7
  genvar gi;
  generate
    for (gi = 0; gi < dio_pkg::IRQ_LVL_NUM; gi++) begin : g_irq
      assign irq_o[gi] = st_reg.irq_buf && (st_reg.lvl == 3'(gi + dio_pkg::IRQ_LVL_MIN));
    end
  endgenerate
endmodule

// ### tb/dio_card_asserts.sv
`timescale 1ns/1ns
// ====
// pin-level checks of the card front end
module dio_card_asserts (
  input wire logic core_clk_i, rst_n_i, aen_i, ior_n_i, iow_n_i, wait_en_i,
  input wire logic data_oe_o, io_ready_o, port_a_byte_oe_o, mode_b_o,
  input wire logic [9:0] addr_i,
  input wire logic [7:0] data_i, base_sw_off_i, port_a_byte_o,
  input wire logic [7:0] port_c_byte_i, port_c_byte_o, port_c_byte_oe_o,
  input wire logic [5:0] irq_o,
  input wire logic [2:0] irq_level_i
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  // decode rebuilt from the pins; a dma cycle never selects
  wire sel = !aen_i && addr_i[9:2] == base_sw_off_i;
  wire rd = sel && !ior_n_i;
  wire wr = sel && !iow_n_i;
  wire cyc = rd || wr;
  // shared lines read back from whoever drives them
  wire src = port_c_byte_oe_o[3] ? port_c_byte_o[3] : port_c_byte_i[3];
  wire dis = port_c_byte_oe_o[7] ? port_c_byte_o[7] : port_c_byte_i[7];
  sequence ctl_wr;
    wr && addr_i[1:0] == 2'h3 && data_i[7] && !$past(wr);
  endsequence
  sequence a_wr;
    wr && addr_i[1:0] == 2'h0 && !$past(wr) && port_a_byte_oe_o;
  endsequence
  a_oe_needs_read: assert property (data_oe_o |-> rd) else $error("drive outside a card read");
  a_oe_on_read: assert property (rd |-> data_oe_o) else $error("card read not driven");
  a_wait_one: assert property (cyc && !$past(cyc) && wait_en_i |-> !io_ready_o ##1 io_ready_o)
    else $error("wait state not one clock");
  a_no_wait: assert property (!wait_en_i && cyc |-> io_ready_o) else $error("wait without option");
  a_irq_one: assert property ($onehot0(irq_o)) else $error("more than one level driven");
  // the buffer register follows the lines one clock behind
  a_irq_gate: assert property (irq_o != 6'h0 |-> $past(src && !dis, 1)) else $error("irq not gated");
  a_irq_level: assert property ((src && !dis && irq_level_i >= 3'h2 && $stable(irq_level_i)) [*3]
    |-> irq_o == 6'h1 << (irq_level_i - 3'h2)) else $error("irq on wrong level");
  a_rst_inputs: assert property ($rose(rst_n_i) |-> port_c_byte_oe_o == 8'h0 && !port_a_byte_oe_o)
    else $error("lines driven after reset");
  a_dir_set: assert property (ctl_wr |=> port_a_byte_oe_o != $past(data_i[4]) && mode_b_o == $past(data_i[2])
    && port_c_byte_oe_o == {{4{!$past(data_i[3])}}, {4{!$past(data_i[0])}}}) else $error("direction wrong");
  a_latch_a: assert property (a_wr |=> port_a_byte_o == $past(data_i)) else $error("port a not latched");
endmodule
bind dio_card dio_card_asserts u_chk (.*);

// ### tb/dio_host.sv
`timescale 1ns/1ns
// ====
// host processor running i/o cycles
module dio_host (
  input wire logic clk_i,
  input wire logic io_ready_i,
  input wire logic [7:0] data_i,
  output logic [9:0] addr_o,
  output logic aen_o,
  output logic ior_n_o,
  output logic iow_n_o,
  output logic [7:0] data_o
);
  logic [7:0] base = 8'hb7; // window at 2dc, legal for both host classes
  initial {aen_o, ior_n_o, iow_n_o, addr_o, data_o} = {1'b0, 2'h3, 18'h0};
  // strobe held until ready is seen or 8 clocks pass; reads stay one clock longer for the data
  task automatic cyc(input logic [1:0] ofs, input logic rd, input logic dma, input logic [7:0] d,
                     output logic [7:0] q, output logic ok);
    int n;
    logic seen;
    n = 0;
    seen = 1'b0;
    q = 8'h00;
    @(negedge clk_i);
    {aen_o, addr_o, data_o} <= {dma, base, ofs, d};
    if (rd) ior_n_o <= 1'b0;
    else iow_n_o <= 1'b0;
    // ready is read once settled, as the coming rising edge will see it, never in the edge's own step
    while (!seen && n < 8) begin
      #1;
      seen = (io_ready_i === 1'b1);
      @(posedge clk_i);
      n++;
    end
    // read data is registered at the accepting edge; take it just after, strobe held one clock more
    if (rd) begin
      #1;
      q = data_i;
      @(posedge clk_i);
    end
    ok = seen;
    @(negedge clk_i);
    {ior_n_o, iow_n_o, data_o} <= {2'h3, ~d}; // released bus shows no stale byte
  endtask
endmodule

// ### tb/dio_card_tb.sv
`timescale 1ns/1ns
// ====
// directed bench for the card front end
module dio_card_tb;
  logic clk = 1'b0, rst_n = 1'b0, wait_en = 1'b0, aen, ior_n, iow_n, oe, rdy, a_oe, b_oe, mode_b, ok;
  logic [9:0] addr;
  logic [7:0] wd, rdat, pa, pb, pc, pc_oe, q, pa_i = 8'hc3, pb_i = 8'h3c, pc_i = 8'h71;
  logic [7:0] ctl [4] = '{8'h88, 8'ha3, 8'hc6, 8'he0};
  logic [7:0] cexp [4] = '{8'h14, 8'h48, 8'hac, 8'h9c};
  logic [7:0] rexp [4] = '{8'hc3, 8'h3c, 8'h71, 8'h00};
  logic [5:0] irq;
  logic [2:0] lvl = 3'h2;
  logic [1:0] mode_a;
  int num_errors = 0, compares = 0;
  initial forever #20 clk = ~clk;
  dio_card u_dut (.core_clk_i(clk), .rst_n_i(rst_n), .addr_i(addr), .aen_i(aen), .ior_n_i(ior_n), .iow_n_i(iow_n),
    .data_i(wd), .data_o(rdat), .data_oe_o(oe), .io_ready_o(rdy), .irq_o(irq), .base_sw_off_i(8'hb7),
    .wait_en_i(wait_en), .irq_level_i(lvl), .port_a_byte_i(pa_i), .port_a_byte_o(pa), .port_a_byte_oe_o(a_oe),
    .port_b_byte_i(pb_i), .port_b_byte_o(pb), .port_b_byte_oe_o(b_oe), .port_c_byte_i(pc_i),
    .port_c_byte_o(pc), .port_c_byte_oe_o(pc_oe), .mode_a_o(mode_a), .mode_b_o(mode_b));
  dio_host u_host (.clk_i(clk), .io_ready_i(rdy), .data_i(rdat), .addr_o(addr), .aen_o(aen), .ior_n_o(ior_n),
    .iow_n_o(iow_n), .data_o(wd));
  // ====
  // compare, verdict and access helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // a hung cycle ends the run at once
  task automatic acc(input logic [1:0] ofs, input logic rd, input logic dma, input logic [7:0] d);
    u_host.cyc(ofs, rd, dma, d, q, ok);
    if (!ok) begin
      num_errors++;
      end_of_test;
    end
  endtask
  // ====
  // main sequence
  initial begin
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    chk(pc_oe | {a_oe, b_oe, 6'h0}, 8'h0);
    acc(2'h3, 1'b0, 1'b0, 8'h80);
    chk(pc_oe, 8'hff);
    acc(2'h0, 1'b0, 1'b0, 8'h5a);
    acc(2'h0, 1'b0, 1'b1, 8'h11);
    u_host.base = 8'hb6;
    acc(2'h0, 1'b0, 1'b0, 8'h22);
    u_host.base = 8'hb7;
    chk(pa, 8'h5a);
    acc(2'h1, 1'b0, 1'b0, 8'ha5);
    chk(pb, 8'ha5);
    // nibble splits and every group mode
    for (int i = 0; i < 4; i++) begin
      acc(2'h3, 1'b0, 1'b0, ctl[i]);
      chk({mode_a, mode_b, b_oe, pc_oe[7], pc_oe[0], 2'h0}, cexp[i]);
    end
    // all inputs, each offset read with the wait option on
    wait_en = 1'b1;
    acc(2'h3, 1'b0, 1'b0, 8'h9b);
    for (int i = 0; i < 4; i++) begin
      acc(2'(i), 1'b1, 1'b0, 8'h0);
      chk(q, rexp[i]);
    end
    wait_en = 1'b0;
    // request on c3 walked over every jumper level, then disabled by c7
    acc(2'h3, 1'b0, 1'b0, 8'h80);
    acc(2'h2, 1'b0, 1'b0, 8'h08);
    for (int l = 2; l < 8; l++) begin
      lvl = 3'(l);
      repeat (3) @(negedge clk);
      chk({2'h0, irq}, 8'(8'h1 << (l - 2)));
    end
    acc(2'h2, 1'b0, 1'b0, 8'h88);
    repeat (3) @(negedge clk);
    chk({2'h0, irq}, 8'h0);
    // single-line reset of c7 through the control byte lets the request through again
    acc(2'h3, 1'b0, 1'b0, 8'h0e);
    repeat (3) @(negedge clk);
    chk({2'h0, irq}, 8'h20);
    end_of_test;
  end
endmodule
